// >>> logic/ccsi_pkg.sv
// What this block does
// - Transmitting: good token CRC sets data CRC status, bad token clears it
// - Receiving: good data-block CRC16 sets data CRC status, bad clears it
// - Matching response CRC7 sets the response CRC status, bit 2
// - Correct response format sets status bit 1, wrong format clears it
// - Status bits 7 and 6 read zero; software writes no ones there
// - Busy line asserting or releasing sets the busy change flag, bit 7
// - Completed response reception sets the response done flag, bit 6
// - Completed command transmission sets the command done flag, bit 5
// - Completed stream or block frame sets the frame done flag, bit 4
// - Reading the flag register clears the four event flags
// - FIFO B full flag, bit 3, sets on full, clears on empty
// - FIFO A full flag, bit 2, sets on full, clears on empty
// - FIFO B empty flag, bit 1, sets on empty, clears on full
// - FIFO A empty flag, bit 0, sets on empty, clears on full
// - Mask bit matches flag position; one blocks, zero allows interrupt
// - Unmasked set flag with global enable raises the interrupt
// - Mask register resets to all ones
`default_nettype none

package ccsi_pkg;

  // ***************************************************************
  // Register indices (byte address is four times the index)
  // ***************************************************************
  localparam logic [7:0] IDX_STATUS = 8'h00DE;
  localparam logic [7:0] IDX_MASK   = 8'h00DF;
  localparam logic [7:0] IDX_CTRL   = 8'h00E0;
  localparam logic [7:0] IDX_FLAGS  = 8'h00E7;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int ST_BUSY      = 5;
  localparam int ST_DATA_CRC  = 4;
  localparam int ST_RESP_CRC  = 2;
  localparam int ST_RESP_FMT  = 1;

  localparam int FL_BUSY_CHG  = 7;
  localparam int FL_RESP_DONE = 6;
  localparam int FL_CMD_DONE  = 5;
  localparam int FL_FRAME     = 4;
  localparam int FL_B_FULL    = 3;
  localparam int FL_A_FULL    = 2;
  localparam int FL_B_EMPTY   = 1;
  localparam int FL_A_EMPTY   = 0;

  localparam int CTRL_GIE     = 0;

  // ***************************************************************
  // Reset values and bus codes
  // ***************************************************************
  localparam logic [7:0] MASK_RESET   = 8'h00FF;
  localparam logic [7:0] FLAGS_RESET  = 8'h0000;
  localparam logic [7:0] STATUS_RESET = 8'h0000;
  localparam logic [7:0] EVENT_BITS   = 8'h00F0;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam int         ADDR_W_MIN   = 10;

  typedef enum logic [1:0]
  {
    CCSI_RD_IDLE = 2'b00,
    CCSI_RD_RESP = 2'b01
  } ccsi_rd_state_t;

endpackage

`default_nettype wire

// >>> logic/ccsi_card_status_irq.sv
`timescale 1ns/1ps
`default_nettype none

module ccsi_card_status_irq
  import ccsi_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input  wire  logic              clk,
  input  wire  logic              reset,
  // AXI4-Lite slave
  input  wire  logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic [2:0]        s_axi_awprot,
  input  wire  logic              s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  input  wire  logic              s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  input  wire  logic [ADDR_W-1:0] s_axi_araddr,
  input  wire  logic [2:0]        s_axi_arprot,
  input  wire  logic              s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  // Card data line busy level, asynchronous
  input  wire  logic              card_data_busy_pin,
  // Command, data and FIFO engine events
  input  wire  logic              data_dir_tx,
  input  wire  logic              token_crc_good,
  input  wire  logic              token_crc_bad,
  input  wire  logic              block_crc_good,
  input  wire  logic              block_crc_bad,
  input  wire  logic              resp_crc_good,
  input  wire  logic              resp_crc_bad,
  input  wire  logic              resp_format_good,
  input  wire  logic              resp_format_bad,
  input  wire  logic              resp_done,
  input  wire  logic              cmd_done,
  input  wire  logic              frame_done,
  input  wire  logic              fifo_a_full,
  input  wire  logic              fifo_a_empty,
  input  wire  logic              fifo_b_full,
  input  wire  logic              fifo_b_empty,
  // Controller interrupt request
  output logic                    card_irq
);

  // ***************************************************************
  // Elaboration check
  // ***************************************************************
  generate
    if (ADDR_W < ADDR_W_MIN)
    begin : g_bad_addr_w
      $error("ADDR_W too narrow for the register map");
    end
  endgenerate

  // ***************************************************************
  // Address decode
  // ***************************************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [7:0]        idx);
    reg_hit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  // ***************************************************************
  // Registers
  // ***************************************************************
  logic [7:0]        mask_reg;
  logic [7:0]        mask_next;
  logic              gie_reg;
  logic              gie_next;
  logic [7:0]        flags_reg;
  logic [7:0]        flags_next;
  logic              data_crc_ok_reg;
  logic              resp_crc_ok_reg;
  logic              resp_format_ok_reg;
  logic              busy_meta_reg;
  logic              busy_sync_reg;
  logic              busy_prev_reg;
  logic              fa_full_prev_reg;
  logic              fa_empty_prev_reg;
  logic              fb_full_prev_reg;
  logic              fb_empty_prev_reg;
  logic              irq_reg;

  logic              aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              w_full_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  ccsi_rd_state_t    rd_state_reg;
  ccsi_rd_state_t    rd_state_next;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;

  // ***************************************************************
  // Write channel
  // ***************************************************************
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;

  wire wr_mask   = reg_hit(aw_addr_reg, IDX_MASK);
  wire wr_ctrl   = reg_hit(aw_addr_reg, IDX_CTRL);
  wire wr_status = reg_hit(aw_addr_reg, IDX_STATUS);
  wire wr_flags  = reg_hit(aw_addr_reg, IDX_FLAGS);
  wire wr_mapped = wr_mask || wr_ctrl || wr_status || wr_flags;

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Status and flag writes are accepted but change nothing
  assign mask_next = (do_write && wr_mask && w_strb_reg[0])
                   ? w_data_reg[7:0] : mask_reg;
  assign gie_next  = (do_write && wr_ctrl && w_strb_reg[0])
                   ? w_data_reg[CTRL_GIE] : gie_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_full_reg <= 1'b1;
      else if (do_write)
        aw_full_reg <= 1'b0;
      if (w_take)
        w_full_reg <= 1'b1;
      else if (do_write)
        w_full_reg <= 1'b0;
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (aw_take)
      aw_addr_reg <= s_axi_awaddr;
    if (w_take)
    begin
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // ***************************************************************
  // Read channel
  // ***************************************************************
  wire ar_take   = s_axi_arvalid && s_axi_arready;
  wire rd_mask   = reg_hit(s_axi_araddr, IDX_MASK);
  wire rd_ctrl   = reg_hit(s_axi_araddr, IDX_CTRL);
  wire rd_status = reg_hit(s_axi_araddr, IDX_STATUS);
  wire rd_flags  = reg_hit(s_axi_araddr, IDX_FLAGS);
  wire rd_mapped = rd_mask || rd_ctrl || rd_status || rd_flags;
  wire rd_clear  = ar_take && rd_flags;

  // Reserved and unimplemented status bits read as zero
  wire [7:0] status_view = {2'b00,
                            busy_sync_reg,
                            data_crc_ok_reg,
                            1'b0,
                            resp_crc_ok_reg,
                            resp_format_ok_reg,
                            1'b0};

  wire [7:0] rd_byte = rd_mask   ? mask_reg :
                       rd_ctrl   ? {7'b000_0000, gie_reg} :
                       rd_status ? status_view :
                       rd_flags  ? flags_reg : 8'h0000;

  assign s_axi_arready = (rd_state_reg == CCSI_RD_IDLE);
  assign s_axi_rvalid  = (rd_state_reg == CCSI_RD_RESP);
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb
  begin
    rd_state_next = rd_state_reg;
    case (rd_state_reg)
      CCSI_RD_IDLE:
        if (s_axi_arvalid)
          rd_state_next = CCSI_RD_RESP;
      CCSI_RD_RESP:
        if (s_axi_rready)
          rd_state_next = CCSI_RD_IDLE;
      default:
        rd_state_next = CCSI_RD_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_state_reg <= CCSI_RD_IDLE;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= RESP_OKAY;
    end
    else
    begin
      rd_state_reg <= rd_state_next;
      if (ar_take)
      begin
        rdata_reg <= {24'h00_0000, rd_byte};
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ***************************************************************
  // Busy line synchroniser and edge detect
  // ***************************************************************
  wire busy_edge = busy_sync_reg ^ busy_prev_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_meta_reg <= 1'b0;
      busy_sync_reg <= 1'b0;
      busy_prev_reg <= 1'b0;
    end
    else
    begin
      busy_meta_reg <= card_data_busy_pin;
      busy_sync_reg <= busy_meta_reg;
      busy_prev_reg <= busy_sync_reg;
    end
  end

  // ***************************************************************
  // FIFO level transitions
  // ***************************************************************
  wire fa_full_rise  = fifo_a_full && !fa_full_prev_reg;
  wire fa_empty_rise = fifo_a_empty && !fa_empty_prev_reg;
  wire fb_full_rise  = fifo_b_full && !fb_full_prev_reg;
  wire fb_empty_rise = fifo_b_empty && !fb_empty_prev_reg;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      fa_full_prev_reg  <= 1'b0;
      fa_empty_prev_reg <= 1'b0;
      fb_full_prev_reg  <= 1'b0;
      fb_empty_prev_reg <= 1'b0;
    end
    else
    begin
      fa_full_prev_reg  <= fifo_a_full;
      fa_empty_prev_reg <= fifo_a_empty;
      fb_full_prev_reg  <= fifo_b_full;
      fb_empty_prev_reg <= fifo_b_empty;
    end
  end

  // ***************************************************************
  // Flag update: a set in the clearing cycle wins
  // ***************************************************************
  wire [7:0] event_set = {busy_edge,
                          resp_done,
                          cmd_done,
                          frame_done,
                          4'b0000};

  wire [7:0] event_keep = rd_clear ? (flags_reg & ~EVENT_BITS)
                                   : flags_reg;

  always_comb
  begin
    flags_next = (event_keep | event_set) & EVENT_BITS;
    flags_next[FL_B_FULL] = fb_full_rise ? 1'b1 :
                            fb_empty_rise ? 1'b0 :
                            flags_reg[FL_B_FULL];
    flags_next[FL_A_FULL] = fa_full_rise ? 1'b1 :
                            fa_empty_rise ? 1'b0 :
                            flags_reg[FL_A_FULL];
    flags_next[FL_B_EMPTY] = fb_empty_rise ? 1'b1 :
                             fb_full_rise ? 1'b0 :
                             flags_reg[FL_B_EMPTY];
    flags_next[FL_A_EMPTY] = fa_empty_rise ? 1'b1 :
                             fa_full_rise ? 1'b0 :
                             flags_reg[FL_A_EMPTY];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags_reg <= FLAGS_RESET;
      mask_reg  <= MASK_RESET;
      gie_reg   <= 1'b0;
    end
    else
    begin
      flags_reg <= flags_next;
      mask_reg  <= mask_next;
      gie_reg   <= gie_next;
    end
  end

  // ***************************************************************
  // Check result status
  // ***************************************************************
  wire crc16_good = data_dir_tx ? token_crc_good : block_crc_good;
  wire crc16_bad  = data_dir_tx ? token_crc_bad : block_crc_bad;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      data_crc_ok_reg    <= STATUS_RESET[ST_DATA_CRC];
      resp_crc_ok_reg    <= STATUS_RESET[ST_RESP_CRC];
      resp_format_ok_reg <= STATUS_RESET[ST_RESP_FMT];
    end
    else
    begin
      if (crc16_good)
        data_crc_ok_reg <= 1'b1;
      else if (crc16_bad)
        data_crc_ok_reg <= 1'b0;
      if (resp_crc_good)
        resp_crc_ok_reg <= 1'b1;
      else if (resp_crc_bad)
        resp_crc_ok_reg <= 1'b0;
      if (resp_format_good)
        resp_format_ok_reg <= 1'b1;
      else if (resp_format_bad)
        resp_format_ok_reg <= 1'b0;
    end
  end

  // ***************************************************************
  // Interrupt request
  // ***************************************************************
  wire irq_next = gie_reg && |(flags_reg & ~mask_reg);

  always_ff @(posedge clk)
  begin
    if (reset)
      irq_reg <= 1'b0;
    else
      irq_reg <= irq_next;
  end

  assign card_irq = irq_reg;

endmodule

`default_nettype wire

// >>> dv/ccsi_card_model.sv
`timescale 1ns/1ps
`default_nettype none

module ccsi_card_model
#(
  parameter int BUSY_CYCLES = 20
)
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic start,
  output logic      busy_pin
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  // Card holds the data line busy for a set time after a block
  assign count_next = start ? 8'(BUSY_CYCLES)
    : (count_reg != 8'h00) ? count_reg - 8'h01 : count_reg;
  always_ff @(posedge clk)
  begin
    if (reset)
      count_reg <= 8'h00;
    else
      count_reg <= count_next;
  end
  // Line moves 33 ns after the host clock edge, away from the sampling edge
  assign #33 busy_pin = (count_reg != 8'h00);
endmodule

`default_nettype wire

// >>> dv/ccsi_chk.sv
`timescale 1ns/1ps
`default_nettype none

module ccsi_chk
  import ccsi_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              clk,
  input wire logic              reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              resp_done,
  input wire logic              cmd_done,
  input wire logic              frame_done,
  input wire logic              card_irq
);
  localparam int IW = ADDR_W - 2;
  logic [IW-1:0] ar_idx;
  logic [IW-1:0] aw_idx;
  logic          ar_map;
  logic          ar_take;
  logic [7:0]    mask_reg;
  logic          gie_reg;
  assign ar_idx = s_axi_araddr[ADDR_W-1:2];
  assign aw_idx = s_axi_awaddr[ADDR_W-1:2];
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_map = ar_idx == IW'(IDX_STATUS) || ar_idx == IW'(IDX_MASK)
    || ar_idx == IW'(IDX_CTRL) || ar_idx == IW'(IDX_FLAGS);
  // Shadow of mask and enable, updated late so it never leads the design
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mask_reg <= MASK_RESET;
      gie_reg  <= 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      if (aw_idx == IW'(IDX_MASK))
        mask_reg <= s_axi_wdata[7:0];
      if (aw_idx == IW'(IDX_CTRL))
        gie_reg <= s_axi_wdata[CTRL_GIE];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property ev_irq_p(ev, m);
    ev && gie_reg && !m |-> ##2 card_irq;
  endproperty
  resp_irq_a:
    assert property (ev_irq_p(resp_done, mask_reg[6]))
    else $error("response done left the interrupt low");
  cmd_irq_a:
    assert property (ev_irq_p(cmd_done, mask_reg[5]))
    else $error("command done left the interrupt low");
  frame_irq_a:
    assert property (ev_irq_p(frame_done, mask_reg[4]))
    else $error("frame done left the interrupt low");
  mask_quiet_a:
    assert property ((mask_reg == 8'hFF) [*4] |-> !card_irq)
    else $error("masked flags raised the interrupt");
  gie_quiet_a:
    assert property ((!gie_reg) [*4] |-> !card_irq)
    else $error("interrupt raised while disabled");
  rd_answer_a:
    assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  unmap_rd_a:
    assert property (ar_take && !ar_map |=> s_axi_rresp == RESP_SLVERR
      && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  rsv_zero_a:
    assert property (ar_take && ar_idx == IW'(IDX_STATUS)
      |=> s_axi_rdata[7:6] == 2'b00 && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("status reserved bits not zero");
  irq_c: cover property ($rose(card_irq));
  unmap_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  masked_c: cover property (cmd_done && mask_reg[5]);
endmodule

bind ccsi_card_status_irq ccsi_chk #(.ADDR_W(ADDR_W)) i_ccsi_chk
(
  .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .resp_done, .cmd_done, .frame_done, .card_irq
);

`default_nettype wire

// >>> dv/test_ccsi_card_status_irq.sv
`timescale 1ns/1ps
`default_nettype none

module test_ccsi_card_status_irq
  import ccsi_pkg::*;
;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        data_dir_tx = 1'b0;
  logic        busy_start = 1'b0;
  logic [14:0] ev = 15'h0000;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, card_irq, busy_pin;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata;
  logic [7:0]  d, e;
  int          bad_count = 0;
  int          tests_run = 0;

  ccsi_card_status_irq #(.ADDR_W(12)) i_ccsi_card_status_irq
  (
    .clk, .reset, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .card_data_busy_pin(busy_pin), .data_dir_tx,
    .token_crc_good(ev[0]), .token_crc_bad(ev[1]), .block_crc_good(ev[2]),
    .block_crc_bad(ev[3]), .resp_crc_good(ev[4]), .resp_crc_bad(ev[5]),
    .resp_format_good(ev[6]), .resp_format_bad(ev[7]), .resp_done(ev[8]),
    .cmd_done(ev[9]), .frame_done(ev[10]), .fifo_a_full(ev[11]),
    .fifo_a_empty(ev[12]), .fifo_b_full(ev[13]), .fifo_b_empty(ev[14]),
    .card_irq
  );
  ccsi_card_model #(.BUSY_CYCLES(20)) i_ccsi_card_model
  (
    .clk, .reset, .start(busy_start), .busy_pin
  );

  always #50 clk = ~clk;

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] v);
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= {24'h00_0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tick(1);
  endtask

  task rd(input logic [7:0] idx);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tick(1);
  endtask

  task pulse(input int k);
    ev[k] <= 1'b1;
    tick(1);
    ev[k] <= 1'b0;
    tick(2);
  endtask

  task t_reset;
    rd(IDX_MASK);
    chk(d, MASK_RESET, "mask reset");
    rd(IDX_STATUS);
    chk(d, STATUS_RESET, "status reset");
    rd(8'h10);
    chk(r, RESP_SLVERR, "unmapped read");
    wr(8'h10, 8'hFF);
    chk(r, RESP_SLVERR, "unmapped write");
    wr(IDX_FLAGS, 8'hFF);
    chk(r, RESP_OKAY, "flags write resp");
    wr(IDX_STATUS, 8'h3F);
    chk(r, RESP_OKAY, "status write resp");
    rd(IDX_FLAGS);
    chk(d, FLAGS_RESET, "flags after write");
    rd(IDX_STATUS);
    chk(d, STATUS_RESET, "status after write");
    $display("test reset done");
  endtask

  task t_events;
    wr(IDX_MASK, 8'h00);
    wr(IDX_CTRL, 8'h01);
    for (int i = 0; i < 3; i++)
    begin
      pulse(8 + i);
      chk(card_irq, 1'b1, "irq on event");
      rd(IDX_FLAGS);
      chk(d, 8'h40 >> i, "event flag");
      rd(IDX_FLAGS);
      chk(d, 8'h00, "flag after read");
      chk(card_irq, 1'b0, "irq after read");
    end
    ev[9:8] <= 2'b11;
    tick(1);
    ev[9:8] <= 2'b00;
    tick(2);
    rd(IDX_FLAGS);
    chk(d, 8'h60, "two events");
    chk(d[FL_RESP_DONE], 1'b1, "saved resp flag");
    chk(d[FL_CMD_DONE], 1'b1, "saved cmd flag");
    // Event arrives on the very edge that takes the clearing read
    ev[8] <= 1'b1;
    fork
      rd(IDX_FLAGS);
      begin
        tick(1);
        ev[8] <= 1'b0;
      end
    join
    chk(d, 8'h00, "read in set cycle");
    rd(IDX_FLAGS);
    chk(d, 8'h40, "set beats clear");
    $display("test events done");
  endtask

  task t_status;
    int b;
    pulse(9);
    for (int i = 0; i < 8; i++)
    begin
      b = (i < 4) ? ST_DATA_CRC : (i < 6) ? ST_RESP_CRC : ST_RESP_FMT;
      data_dir_tx <= (i < 2);
      pulse(i);
      rd(IDX_STATUS);
      chk(d[b], !i[0], "status bit");
      chk(d[7:6], 2'b00, "reserved bits");
    end
    rd(IDX_FLAGS);
    chk(d, 8'h20, "flags kept");
    $display("test status done");
  endtask

  task t_fifo;
    e = 8'h00;
    for (int k = 0; k < 2; k++)
    begin
      pulse(11 + 2 * k);
      e = (e | (8'h04 << k)) & ~(8'h01 << k);
      rd(IDX_FLAGS);
      chk(d, e, "fifo full");
      rd(IDX_FLAGS);
      chk(d, e, "fifo full kept");
      pulse(12 + 2 * k);
      e = (e | (8'h01 << k)) & ~(8'h04 << k);
      rd(IDX_FLAGS);
      chk(d, e, "fifo empty");
    end
    $display("test fifo done");
  endtask

  task t_busy;
    busy_start <= 1'b1;
    tick(1);
    busy_start <= 1'b0;
    tick(6);
    rd(IDX_STATUS);
    chk(d[ST_BUSY], 1'b1, "busy level");
    rd(IDX_FLAGS);
    chk(d & EVENT_BITS, 8'h80, "busy entry");
    tick(20);
    rd(IDX_STATUS);
    chk(d[ST_BUSY], 1'b0, "busy released");
    rd(IDX_FLAGS);
    chk(d & EVENT_BITS, 8'h80, "busy exit");
    $display("test busy done");
  endtask

  task t_mask;
    wr(IDX_MASK, 8'hFF);
    chk(card_irq, 1'b0, "irq all masked");
    pulse(9);
    chk(card_irq, 1'b0, "irq event masked");
    wr(IDX_MASK, 8'hDF);
    tick(2);
    chk(card_irq, 1'b1, "irq unmasked");
    rd(IDX_MASK);
    chk(d, 8'hDF, "mask readback");
    wr(IDX_CTRL, 8'h00);
    tick(2);
    chk(card_irq, 1'b0, "irq disabled");
    rd(IDX_FLAGS);
    chk(d & EVENT_BITS, 8'h20, "masked flag kept");
    $display("test mask done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    tick(5);
    reset <= 1'b0;
    t_reset;
    t_events;
    t_status;
    t_fifo;
    t_busy;
    t_mask;
    close_out;
  end

  initial
  begin
    tick(5000);
    bad_count++;
    close_out;
  end
endmodule

`default_nettype wire
